/* File: logic/nv_register_access.v */
// cpu-side register access to the 1024-byte data storage array
// assumes single-cycle register strobes from the cpu on the same clock,
// and that the cpu honours cpu_stall and keeps the arm-then-write order
`timescale 1ns/100ps
`include "nv_access_defs.vh"
module nv_register_access #(
  parameter OSC_DIV = `OSC_DIV,
  parameter WRITE_TICKS = `WRITE_OSC_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire global_irq_enable,
  output wire ready_irq,
  output wire cpu_stall
);

  // storage array, no reset
  reg [7:0] nv_mem [0:`NV_DEPTH-1];

  // software-visible registers
  reg [`NV_ADDR_W-1:0] nv_address_ff; // ten-bit byte address
  reg [7:0] nv_data_byte_ff; // data register
  reg ready_irq_enable_ff; // ready interrupt enable
  reg write_arm_ff; // master write arm
  reg write_strobe_busy_ff; // write in progress

  // timers in cpu cycles
  reg [2:0] arm_cnt_ff; // cycles left in arm window
  reg [2:0] stall_cnt_ff; // cycles left to halt the cpu

  // values captured at write start
  reg [`NV_ADDR_W-1:0] wr_addr_ff;
  reg [7:0] wr_data_ff;

  // completion pulse synchroniser from the write engine
  reg done_s1_ff;
  reg done_s2_ff;

  // next-state values
  reg [`NV_ADDR_W-1:0] nxt_nv_address;
  reg [7:0] nxt_nv_data_byte;
  reg nxt_ready_irq_enable;
  reg nxt_write_arm;
  reg nxt_write_strobe_busy;
  reg [2:0] nxt_arm_cnt;
  reg [2:0] nxt_stall_cnt;
  reg [7:0] nxt_reg_rdata;

  // decoded strobes
  wire ctl_wr; // control register written
  wire hi_wr; // high address written
  wire lo_wr; // low address written
  wire data_wr; // data register written
  wire write_start; // accepted write
  wire read_start; // accepted read

  // engine outputs
  wire osc_tick; // 1 mhz enable
  wire engine_busy; // engine running
  wire engine_done; // engine finished

  // register address decode
  function sel_hit;
    input [1:0] sel;
    input [1:0] code;
    input strobe;
    begin
      sel_hit = strobe && (sel == code);
    end
  endfunction

  assign ctl_wr = sel_hit(reg_sel, `SEL_CONTROL, reg_wr);
  assign hi_wr = sel_hit(reg_sel, `SEL_ADDR_HIGH, reg_wr);
  assign lo_wr = sel_hit(reg_sel, `SEL_ADDR_LOW, reg_wr);
  assign data_wr = sel_hit(reg_sel, `SEL_DATA, reg_wr);

  // write starts only when armed and idle
  assign write_start = ctl_wr && reg_wdata[`CTL_WRITE_STROBE] &&
                       write_arm_ff && !write_strobe_busy_ff; // [RL10]

  // read refused while a write runs
  assign read_start = ctl_wr && reg_wdata[`CTL_READ_STROBE] &&
                      !write_strobe_busy_ff; // [RL12]

  // level request while idle and both enables set
  assign ready_irq = ready_irq_enable_ff && global_irq_enable &&
                     !write_strobe_busy_ff; // [RL7] [RL8]

  // cpu halted while stall counter runs
  assign cpu_stall = (stall_cnt_ff != `ZERO_COUNT3);

  // oscillator timebase runs only while a write is underway
  osc_tick_gen #(
    .DIV(OSC_DIV)
  ) u_osc_tick_gen (
    .clk(clk),
    .rst_b(rst_b),
    .run(engine_busy),
    .tick(osc_tick)
  );

  // programming-cycle timer
  nv_write_timer #(
    .TICKS(WRITE_TICKS)
  ) u_nv_write_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(write_start),
    .tick(osc_tick),
    .busy(engine_busy),
    .done(engine_done)
  );

  // address register update
  always @* begin
    nxt_nv_address = nv_address_ff;
    if (!write_strobe_busy_ff) begin
      // address frozen during a write [RL12]
      if (hi_wr) begin
        // only two high bits kept [RL2] [RL1]
        nxt_nv_address[`NV_ADDR_HI_MSB:`NV_ADDR_HI_LSB] =
          reg_wdata[`NV_ADDR_HI_MSB-`NV_ADDR_HI_LSB:0];
      end else if (lo_wr) begin
        // low byte [RL1]
        nxt_nv_address[7:0] = reg_wdata;
      end
    end
  end

  // data register update
  always @* begin
    nxt_nv_data_byte = nv_data_byte_ff;
    if (read_start) begin
      // fetched byte available at once [RL5] [RL12]
      nxt_nv_data_byte = nv_mem[nv_address_ff];
    end else if (data_wr) begin
      // software load of write data
      nxt_nv_data_byte = reg_wdata;
    end
  end

  // control register and arm window
  always @* begin
    nxt_ready_irq_enable = ready_irq_enable_ff;
    nxt_write_arm = write_arm_ff;
    nxt_arm_cnt = arm_cnt_ff;
    // arm window counts down each cycle
    if (arm_cnt_ff != `ZERO_COUNT3) begin
      nxt_arm_cnt = arm_cnt_ff - `ONE_COUNT3;
      if (arm_cnt_ff == `ONE_COUNT3) begin
        // hardware clears arm after four cycles [RL10]
        nxt_write_arm = 1'b0;
      end
    end
    if (ctl_wr) begin
      // bit 3 is plain read/write [RL7] [RL9]
      nxt_ready_irq_enable = reg_wdata[`CTL_READY_IE];
      if (reg_wdata[`CTL_WRITE_ARM]) begin
        // software set wins over the timeout clear [RL10]
        nxt_write_arm = 1'b1;
        nxt_arm_cnt = `ARM_WINDOW_CYCLES;
      end else begin
        // writing zero drops the arm
        nxt_write_arm = 1'b0;
        nxt_arm_cnt = `ZERO_COUNT3;
      end
    end
  end

  // write strobe: set on accepted start, cleared on synced completion
  always @* begin
    nxt_write_strobe_busy = write_strobe_busy_ff;
    if (done_s2_ff) begin
      nxt_write_strobe_busy = 1'b0; // [RL11] [RL14]
    end
    if (write_start) begin
      nxt_write_strobe_busy = 1'b1; // [RL11]
    end
  end

  // cpu stall counter
  always @* begin
    nxt_stall_cnt = stall_cnt_ff;
    if (write_start) begin
      nxt_stall_cnt = `WRITE_STALL_CYCLES; // [RL11]
    end else if (read_start) begin
      nxt_stall_cnt = `READ_STALL_CYCLES; // [RL12]
    end else if (stall_cnt_ff != `ZERO_COUNT3) begin
      nxt_stall_cnt = stall_cnt_ff - `ONE_COUNT3;
    end
  end

  // read mux for the cpu port
  always @* begin
    nxt_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_sel)
        `SEL_ADDR_HIGH: begin
          // unimplemented upper bits read zero [RL2]
          nxt_reg_rdata = {`ZERO_HI_PAD,
                           nv_address_ff[`NV_ADDR_HI_MSB:`NV_ADDR_HI_LSB]};
        end
        `SEL_ADDR_LOW: begin
          nxt_reg_rdata = nv_address_ff[7:0];
        end
        `SEL_DATA: begin
          nxt_reg_rdata = nv_data_byte_ff;
        end
        `SEL_CONTROL: begin
          // upper nibble zero, read strobe self-clears [RL6] [RL9]
          nxt_reg_rdata = {`ZERO_CTL_PAD, ready_irq_enable_ff,
                           write_arm_ff, write_strobe_busy_ff, 1'b0};
        end
        default: begin
          nxt_reg_rdata = `ZERO_BYTE;
        end
      endcase
    end
  end

  // completion pulse from the engine, two stages before use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
    end else begin
      done_s1_ff <= engine_done; // [RL14]
      done_s2_ff <= done_s1_ff;
    end
  end

  // register state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // address given a fixed value though software may not rely on it [RL3]
      nv_address_ff <= `ZERO_ADDR;
      nv_data_byte_ff <= `ZERO_BYTE;
      ready_irq_enable_ff <= 1'b0;
      write_arm_ff <= 1'b0;
      write_strobe_busy_ff <= 1'b0;
      arm_cnt_ff <= `ZERO_COUNT3;
      stall_cnt_ff <= `ZERO_COUNT3;
      reg_rdata <= `ZERO_BYTE;
    end else begin
      nv_address_ff <= nxt_nv_address;
      nv_data_byte_ff <= nxt_nv_data_byte;
      ready_irq_enable_ff <= nxt_ready_irq_enable;
      write_arm_ff <= nxt_write_arm;
      write_strobe_busy_ff <= nxt_write_strobe_busy;
      arm_cnt_ff <= nxt_arm_cnt;
      stall_cnt_ff <= nxt_stall_cnt;
      reg_rdata <= nxt_reg_rdata;
    end
  end

  // capture address and data at write start
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_addr_ff <= `ZERO_ADDR;
      wr_data_ff <= `ZERO_BYTE;
    end else if (write_start) begin
      wr_addr_ff <= nv_address_ff; // [RL4]
      wr_data_ff <= nv_data_byte_ff; // [RL4]
    end
  end

  // array commits the byte when the timed cycle ends
  always @(posedge clk) begin
    if (done_s2_ff) begin
      nv_mem[wr_addr_ff] <= wr_data_ff; // [RL4] [RL1]
    end
  end

endmodule

/* File: logic/nv_access_defs.vh */
// constants shared by the data-eeprom register access block
// assumes a single 250 mhz cpu clock and an internal 1 mhz write timebase
//
// Summary of operation
// [RL1] ten-bit address picks one of 1024 bytes
// [RL2] address bits 15..10 read zero, writes ignored
// [RL3] address undefined; software loads it before access
// [RL4] write stores data byte at addressed location
// [RL5] read loads data byte from addressed location
// [RL6] control bits 7..4 read zero, writes ignored
// [RL7] bit 3 enables ready interrupt with global enable
// [RL8] ready interrupt is a level while idle
// [RL9] control bits: arm 2, write 1, read 0
// [RL10] arm self-clears after four cycles; gates write start
// [RL11] write strobe busy until done; stall two cycles
// [RL12] read immediate, stall four; refused while writing
// [RL13] write lasts 8448 one-megahertz oscillator cycles
// [RL14] engine busy/done synchronised before updating strobe, interrupt
`ifndef NV_ACCESS_DEFS_VH
`define NV_ACCESS_DEFS_VH

// register select codes on the cpu i/o port
`define SEL_ADDR_HIGH 2'h0
`define SEL_ADDR_LOW 2'h1
`define SEL_DATA 2'h2
`define SEL_CONTROL 2'h3

// storage geometry
`define NV_ADDR_W 10
`define NV_DEPTH 1024
`define NV_ADDR_HI_MSB 9
`define NV_ADDR_HI_LSB 8

// control register bit positions
`define CTL_READY_IE 3
`define CTL_WRITE_ARM 2
`define CTL_WRITE_STROBE 1
`define CTL_READ_STROBE 0

// reset and filler values
`define ZERO_BYTE 8'h00
`define ZERO_ADDR 10'h000
`define ZERO_HI_PAD 6'h00
`define ZERO_CTL_PAD 4'h0

// timing in cpu cycles
`define ARM_WINDOW_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4
`define ZERO_COUNT3 3'h0
`define ONE_COUNT3 3'h1

// clock rates and write time
`define CPU_CLK_HZ 250000000
`define WRITE_OSC_HZ 1000000
`define WRITE_OSC_CYCLES 8448
`define OSC_DIV (`CPU_CLK_HZ / `WRITE_OSC_HZ)

`endif

/* File: logic/osc_tick_gen.v */
// divider giving one-cycle enables at the write oscillator rate
// assumes run is driven from logic on the same clock
`timescale 1ns/100ps
module osc_tick_gen #(
  parameter DIV = 250
) (
  input wire clk,
  input wire rst_b,
  input wire run,
  output reg tick
);

  reg [15:0] div_cnt_ff; // cycles since last tick
  reg [15:0] nxt_div_cnt;
  reg nxt_tick;

  // next count; restarts whenever the timebase is idle
  always @* begin
    nxt_div_cnt = div_cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_div_cnt = 16'h0000;
    end else if (div_cnt_ff == DIV[15:0] - 16'h0001) begin
      nxt_div_cnt = 16'h0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_div_cnt = div_cnt_ff + 16'h0001;
    end
  end

  // registered counter and tick
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tick <= nxt_tick;
    end
  end

endmodule

/* File: logic/nv_write_timer.v */
// write engine timer: counts oscillator ticks for one programming cycle
// assumes start is a one-cycle pulse and tick an enable on the same clock
`timescale 1ns/100ps
module nv_write_timer #(
  parameter TICKS = 8448
) (
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire tick,
  output reg busy,
  output reg done
);

  reg [23:0] tick_cnt_ff; // ticks still to run
  reg [23:0] nxt_tick_cnt;
  reg nxt_busy;
  reg nxt_done;

  // load on start, count down on each tick
  always @* begin
    nxt_tick_cnt = tick_cnt_ff;
    nxt_busy = busy;
    nxt_done = 1'b0;
    if (start && !busy) begin
      nxt_tick_cnt = TICKS[23:0];
      nxt_busy = 1'b1;
    end else if (busy && tick) begin
      if (tick_cnt_ff == 24'h000001) begin
        nxt_tick_cnt = 24'h000000;
        nxt_busy = 1'b0;
        nxt_done = 1'b1; // [RL13]
      end else begin
        nxt_tick_cnt = tick_cnt_ff - 24'h000001;
      end
    end
  end

  // engine state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= 24'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      busy <= nxt_busy;
      done <= nxt_done;
    end
  end

endmodule

/* File: dv/nv_register_access_props.sv */
// assertions on the storage register port
// assumes only the top module's ports and one clock
`timescale 1ns/100ps
module nv_access_props (
  input wire clk,
  input wire rst_b,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire global_irq_enable,
  input wire ready_irq,
  input wire cpu_stall
);
  reg ie_ff; // shadow of the irq enable
  wire cw = reg_wr && reg_sel == 2'h3; // control write
  wire cr = reg_rd && reg_sel == 2'h3; // control read
  wire rs = cw && reg_wdata[1:0] == 2'h1; // read strobe write
  // shadow follows every control write
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ie_ff <= 1'b0;
    end else if (cw) begin
      ie_ff <= reg_wdata[3];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // arm alone, then strobe with irq enabled
  sequence arm_s;
    cw && reg_wdata[2:0] == 3'h4;
  endsequence
  sequence go_s;
    cw && reg_wdata[3:0] == 4'ha && ready_irq;
  endsequence
  a_irq_needs_enable: assert property (ready_irq |-> global_irq_enable && ie_ff)
    else $error("irq without both enables");
  a_write_in_window: assert property (arm_s ##1 (!reg_wr)[*3] ##1 go_s |=>
    !ready_irq && cpu_stall ##1 cpu_stall ##1 !cpu_stall) else $error("write in window not started");
  a_late_strobe: assert property (arm_s ##1 (!reg_wr)[*4] ##1 go_s |=>
    !cpu_stall && (ready_irq || !global_irq_enable)) else $error("late strobe started a write");
  a_read_stall: assert property (rs && ready_irq |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  a_read_refused: assert property (rs && ie_ff && global_irq_enable && !ready_irq && !cpu_stall |=>
    !cpu_stall) else $error("read accepted while busy");
  a_ctl_reads: assert property (cr |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[0]
    && reg_rdata[3] == $past(ie_ff)) else $error("control read value wrong");
  a_busy_reads: assert property (cr && ie_ff && global_irq_enable |=>
    reg_rdata[1] == !$past(ready_irq)) else $error("busy bit disagrees with irq");
  a_addr_pad: assert property (reg_rd && reg_sel == 2'h0 |=> reg_rdata[7:2] == 6'h00)
    else $error("address pad not zero");
  a_arm_holds: assert property (arm_s ##1 (!reg_wr)[*3] ##1 cr |=> reg_rdata[2])
    else $error("arm cleared early");
  a_arm_expires: assert property (arm_s ##1 (!reg_wr)[*4] ##1 cr |=> !reg_rdata[2])
    else $error("arm not cleared");
endmodule
bind nv_register_access nv_access_props chk_i (.clk(clk), .rst_b(rst_b), .reg_sel(reg_sel),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .global_irq_enable(global_irq_enable), .ready_irq(ready_irq), .cpu_stall(cpu_stall));

/* File: dv/test_nv_register_access.sv */
// self-checking bench for the storage register port
// assumes a shortened write timebase via parameters
`timescale 1ns/100ps
module test_nv_register_access;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [1:0] reg_sel = 2'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg global_irq_enable = 1'b0;
  wire [7:0] reg_rdata;
  wire ready_irq;
  wire cpu_stall;
  integer errors = 0;
  integer check_count = 0;
  integer i;
  reg [7:0] v; // last byte read
  reg [17:0] rows [0:3]; // address beside byte
  nv_register_access #(.OSC_DIV(2), .WRITE_TICKS(4)) uut (.clk(clk), .rst_b(rst_b),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .ready_irq(ready_irq), .cpu_stall(cpu_stall));
  // 250 mhz clock
  initial begin
    forever #2 clk = ~clk;
  end
  // compare and count
  task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // register write, strobe left high
  task wr(input [1:0] s, input [7:0] d);
    begin
      reg_sel <= s;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
    end
  endtask
  // drop strobes for n cycles
  task idle(input integer n);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
    end
  endtask
  // register read into v
  task rd(input [1:0] s);
    begin
      reg_sel <= s;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
    end
  endtask
  // poll busy, bounded
  task wait_idle;
    integer n;
    begin
      n = 0;
      v = 8'h02;
      while (v[1] !== 1'b0 && n < 60) begin
        rd(2'h3);
        n = n + 1;
      end
      if (n >= 60) begin
        errors = errors + 1;
        $display("BAD busy expected 0 seen 1");
      end
    end
  endtask
  task setup(input [9:0] a);
    begin
      wr(2'h0, {6'h00, a[9:8]});
      wr(2'h1, a[7:0]);
    end
  endtask
  // arm then strobe back to back
  task put(input [9:0] a, input [7:0] d);
    begin
      setup(a);
      wr(2'h2, d);
      wr(2'h3, 8'h0c);
      wr(2'h3, 8'h0a);
      idle(2);
      wait_idle;
    end
  endtask
  // read strobe, wait out the stall
  task get(input [9:0] a);
    begin
      setup(a);
      wr(2'h3, 8'h09);
      idle(4);
      rd(2'h2);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    errors = errors + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    rows[0] = {10'h000, 8'h5a};
    rows[1] = {10'h3ff, 8'ha5};
    rows[2] = {10'h155, 8'h3c};
    rows[3] = {10'h2aa, 8'hc3};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    global_irq_enable <= 1'b1;
    rd(2'h3);
    chk("ctl_rst", v, 8'h00);
    rd(2'h0);
    chk("adr_pad", v & 8'hfc, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      put(rows[i][17:8], rows[i][7:0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      get(rows[i][17:8]);
      chk("readback", v, rows[i][7:0]);
    end
    chk("irq_idle", {7'h00, ready_irq}, 8'h01);
    $display("table test done");
    wr(2'h0, 8'hff);
    wr(2'h1, 8'h12);
    wr(2'h3, 8'hf8);
    idle(1);
    rd(2'h0);
    chk("adr_hi", v, 8'h03);
    rd(2'h1);
    chk("adr_lo", v, 8'h12);
    rd(2'h3);
    chk("ctl_pad", v, 8'h08);
    global_irq_enable <= 1'b0;
    idle(1);
    chk("irq_glob", {7'h00, ready_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    wr(2'h3, 8'h00);
    idle(1);
    chk("irq_ie", {7'h00, ready_irq}, 8'h00);
    $display("pad and irq test done");
    wr(2'h3, 8'h0c);
    idle(3);
    rd(2'h3);
    chk("arm_on", v, 8'h0c);
    wr(2'h3, 8'h0c);
    idle(4);
    rd(2'h3);
    chk("arm_off", v, 8'h08);
    put(10'h202, 8'h22);
    wr(2'h2, 8'h11);
    wr(2'h3, 8'h0c);
    idle(4);
    wr(2'h3, 8'h0a);
    idle(2);
    rd(2'h3);
    chk("late", v, 8'h08);
    wr(2'h3, 8'h0a);
    idle(2);
    rd(2'h3);
    chk("no_arm", v, 8'h08);
    get(10'h202);
    chk("kept", v, 8'h22);
    setup(10'h201);
    wr(2'h2, 8'h77);
    wr(2'h3, 8'h0c);
    idle(3);
    wr(2'h3, 8'h0a);
    idle(2);
    wait_idle;
    get(10'h201);
    chk("edge4", v, 8'h77);
    $display("arm window test done");
    setup(10'h0f0);
    wr(2'h2, 8'h99);
    wr(2'h3, 8'h0c);
    wr(2'h3, 8'h0a);
    idle(2);
    chk("irq_busy", {7'h00, ready_irq}, 8'h00);
    rd(2'h3);
    chk("busy", v, 8'h0a);
    wr(2'h1, 8'h55);
    wr(2'h2, 8'h44);
    wr(2'h3, 8'h09);
    idle(1);
    chk("rd_stall", {7'h00, cpu_stall}, 8'h00);
    rd(2'h1);
    chk("adr_keep", v, 8'hf0);
    wait_idle;
    chk("irq_done", {7'h00, ready_irq}, 8'h01);
    get(10'h0f0);
    chk("wr_busy", v, 8'h99);
    get(10'h155);
    chk("other", v, 8'h3c);
    $display("busy test done");
    end_of_test;
  end
endmodule
